//--- pkg/pcbg_pkg.sv
package pcbg_pkg;
    // ==========================================
    // Widths and sizes
    localparam int PIX_W = 12;
    localparam int CH_W = 3;
    localparam int NUM_CH = 8;
    localparam int SEL_W = 4;
    localparam int RATIO_W = 16;
    localparam int FRAC_W = 8;
    localparam int LUT_AW = 6;
    localparam int AWB_WIN_LOG = 8;
    localparam int AWB_MAX_ROUNDS = 64;
    localparam int ACC_W = PIX_W + AWB_WIN_LOG;

    // ==========================================
    // Register byte offsets
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_CLIP_SEL = 8'h04;
    localparam logic [7:0] OFF_CLIP_INT = 8'h08;
    localparam logic [7:0] OFF_CLIP_PHYS = 8'h0c;
    localparam logic [7:0] OFF_BAL_SEL = 8'h10;
    localparam logic [7:0] OFF_BAL_MULT = 8'h14;
    localparam logic [7:0] OFF_BAL_LEGACY = 8'h18;
    localparam logic [7:0] OFF_GAMMA = 8'h1c;
    localparam logic [7:0] OFF_LUT_IDX = 8'h20;
    localparam logic [7:0] OFF_LUT_VAL = 8'h24;
    localparam logic [7:0] OFF_STATUS = 8'h28;

    // ==========================================
    // Field positions and encodings
    localparam int CTRL_LUT_EN = 2;
    localparam int STAT_AWB_BUSY = 0;
    localparam int STAT_GAMMA_ON = 1;
    localparam int STAT_LUT_FREE = 2;
    localparam logic [SEL_W-1:0] CLIP_SEL_ALL = 4'h0;
    localparam logic [CH_W-1:0] CH_RED = 3'h0;
    localparam logic [CH_W-1:0] CH_GREEN = 3'h1;
    localparam logic [CH_W-1:0] CH_BLUE = 3'h2;

    // ==========================================
    // Reset values and tuning
    localparam logic [PIX_W-1:0] CLIP_RST = 12'hfff;
    localparam logic [RATIO_W-1:0] UNITY = 16'h0100;
    localparam logic [RATIO_W-1:0] AWB_STEP = 16'h0004;
    localparam logic [ACC_W-1:0] AWB_TOL = 20'h00400;

    typedef enum logic [1:0] {
        AWB_OFF = 2'h0,
        AWB_ONCE = 2'h1,
        AWB_CONT = 2'h2,
        AWB_HOLD = 2'h3
    } pcbg_awb_mode_e;

    typedef enum logic [1:0] {
        AWB_IDLE = 2'h0,
        AWB_ACC = 2'h1,
        AWB_ADJ = 2'h3
    } pcbg_awb_st_e;

    // ==========================================
    // Shared arithmetic
    function automatic logic [PIX_W-1:0] scale_sat(input logic [PIX_W-1:0] pix,
                                                  input logic [RATIO_W-1:0] r);
        logic [PIX_W+RATIO_W-1:0] prod;
        prod = pix * r;
        scale_sat = (|prod[PIX_W+RATIO_W-1:PIX_W+FRAC_W]) ? '1 : prod[PIX_W+FRAC_W-1:FRAC_W];
    endfunction

    function automatic logic [PIX_W-1:0] clip_min(input logic [PIX_W-1:0] v,
                                                 input logic [PIX_W-1:0] lim);
        clip_min = (v > lim) ? lim : v;
    endfunction

    function automatic logic [31:0] merge32(input logic [31:0] old_v, input logic [31:0] new_v,
                                           input logic [3:0] sel);
        merge32 = old_v;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                merge32[8*b +: 8] = new_v[8*b +: 8];
            end
        end
    endfunction
endpackage

//--- pkg/pcbg_stream_if.sv
`timescale 1ns/1ps
interface pcbg_stream_if #(parameter int DW = 8);
    logic valid;
    logic ready;
    logic [DW-1:0] data;
    modport src(output valid, output data, input ready);
    modport snk(input valid, input data, output ready);
endinterface

//--- rtl/pcbg_fifo.sv
`timescale 1ns/1ps
module pcbg_fifo #(
    parameter int DW = 8,
    parameter int DEPTH = 2
) (
    input wire logic clk,
    input wire logic rst_n,
    pcbg_stream_if.snk up,
    pcbg_stream_if.src dn
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam logic [AW:0] FULL = (AW + 1)'(DEPTH);
    localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);

    logic [DW-1:0] mem_reg [DEPTH];
    logic [AW-1:0] wp_reg;
    logic [AW-1:0] rp_reg;
    logic [AW:0] cnt_reg;
    logic push;
    logic pop;

    // ==========================================
    // Handshake
    assign up.ready = (cnt_reg != FULL);
    assign dn.valid = (cnt_reg != '0);
    assign dn.data = mem_reg[rp_reg];
    assign push = up.valid & up.ready;
    assign pop = dn.valid & dn.ready;

    // ==========================================
    // Storage and pointers
    always_ff @(posedge clk) begin
        if (push) begin
            mem_reg[wp_reg] <= up.data;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wp_reg <= '0;
            rp_reg <= '0;
            cnt_reg <= '0;
        end else begin
            if (push) begin
                wp_reg <= (wp_reg == LAST) ? '0 : wp_reg + 1'b1;
            end
            if (pop) begin
                rp_reg <= (rp_reg == LAST) ? '0 : rp_reg + 1'b1;
            end
            cnt_reg <= cnt_reg + (AW + 1)'(push) - (AW + 1)'(pop);
        end
    end
endmodule

//--- rtl/pcbg_lut.sv
`timescale 1ns/1ps
module pcbg_lut #(
    parameter int AW = 6,
    parameter int DW = 12
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic wr_en,
    input wire logic [AW-1:0] wr_addr,
    input wire logic [DW-1:0] wr_data,
    input wire logic [AW-1:0] sw_addr,
    output logic [DW-1:0] sw_data,
    input wire logic [AW-1:0] lk_addr,
    output logic [DW-1:0] lk_data
);
    logic [DW-1:0] tab_reg [2**AW];

    // ==========================================
    // Lookup ports
    assign sw_data = tab_reg[sw_addr];
    assign lk_data = tab_reg[lk_addr];

    // ==========================================
    // Table, reset to a straight line
    always_ff @(posedge clk) begin
        for (int i = 0; i < 2**AW; i++) begin
            if (!rst_n) begin
                tab_reg[i] <= {AW'(i), {(DW-AW){1'b0}}};
            end else if (wr_en && wr_addr == AW'(i)) begin
                tab_reg[i] <= wr_data;
            end
        end
    end
endmodule

//--- rtl/pcbg_top.sv
`timescale 1ns/1ps
// Operation
// - Clip selector: all, colours, taps
// - Output never exceeds channel clip level
// - Separate clip level per selected channel
// - Clip level also as raw integer
// - Raw and physical clip forms alias
// - Balance selector: colours and taps only
// - Pixel times positive balance multiplier
// - Auto off: manual multipliers only
// - Once: adjust, then return to off
// - Continuous: keep adjusting while selected
// - Extra vendor auto mode allowed
// - Gamma factor strictly positive
// - Gamma occupies lookup table
module pcbg_top #(
    parameter int FIFO_DEPTH = 2
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic wb_cyc,
    input wire logic wb_stb,
    input wire logic wb_we,
    input wire logic [7:0] wb_adr,
    input wire logic [3:0] wb_sel,
    input wire logic [31:0] wb_dat_w,
    output logic [31:0] wb_dat_r,
    output logic wb_ack,
    input wire logic pix_in_valid,
    output logic pix_in_ready,
    input wire logic [pcbg_pkg::PIX_W-1:0] pix_in_data,
    input wire logic [pcbg_pkg::CH_W-1:0] pix_in_chan,
    output logic pix_out_valid,
    input wire logic pix_out_ready,
    output logic [pcbg_pkg::PIX_W-1:0] pix_out_data,
    output logic [pcbg_pkg::CH_W-1:0] pix_out_chan
);
    localparam int PW = pcbg_pkg::PIX_W;
    localparam int CW = pcbg_pkg::CH_W;
    localparam int NC = pcbg_pkg::NUM_CH;
    localparam int RW = pcbg_pkg::RATIO_W;
    localparam int AWL = pcbg_pkg::ACC_W;
    localparam int RND_W = $clog2(pcbg_pkg::AWB_MAX_ROUNDS) + 1;
    localparam logic [RND_W-1:0] RND_LAST = RND_W'(pcbg_pkg::AWB_MAX_ROUNDS - 1);

    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);

    // ==========================================
    // Register state
    logic ack_reg;
    logic [31:0] dat_reg;
    logic [1:0] mode_reg;
    logic lut_en_reg;
    logic [pcbg_pkg::SEL_W-1:0] clip_sel_reg;
    logic [PW-1:0] clip_reg [NC];
    logic [CW-1:0] bal_sel_reg;
    logic [RW-1:0] ratio_reg [NC];
    logic [RW-1:0] gamma_reg;
    logic [pcbg_pkg::LUT_AW-1:0] lut_idx_reg;

    // ==========================================
    // Bus decode
    logic req;
    logic wr;
    logic [7:0] adr_w;
    logic [31:0] rdata;
    logic [31:0] wdat;
    logic [PW-1:0] wdat_pix;
    logic [RW-1:0] wdat_ratio;
    logic hit_ctrl, hit_csel, hit_cint, hit_cphys, hit_bsel, hit_bm, hit_bl;
    logic hit_gam, hit_lidx, hit_lval, hit_stat;
    logic clip_wr, ratio_wr, ctrl_wr;
    logic [CW-1:0] clip_idx;
    logic [PW-1:0] clip_rd;
    logic [PW-1:0] lut_sw_data;
    logic gamma_on;
    logic lut_use;
    pcbg_pkg::pcbg_awb_st_e st_reg;
    pcbg_pkg::pcbg_awb_st_e st_next;

    assign req = wb_cyc & wb_stb & ~ack_reg;
    assign wr = req & wb_we;
    assign adr_w = {wb_adr[7:2], 2'b00};
    assign hit_ctrl = (adr_w == pcbg_pkg::OFF_CTRL);
    assign hit_csel = (adr_w == pcbg_pkg::OFF_CLIP_SEL);
    assign hit_cint = (adr_w == pcbg_pkg::OFF_CLIP_INT);
    assign hit_cphys = (adr_w == pcbg_pkg::OFF_CLIP_PHYS);
    assign hit_bsel = (adr_w == pcbg_pkg::OFF_BAL_SEL);
    assign hit_bm = (adr_w == pcbg_pkg::OFF_BAL_MULT);
    assign hit_bl = (adr_w == pcbg_pkg::OFF_BAL_LEGACY);
    assign hit_gam = (adr_w == pcbg_pkg::OFF_GAMMA);
    assign hit_lidx = (adr_w == pcbg_pkg::OFF_LUT_IDX);
    assign hit_lval = (adr_w == pcbg_pkg::OFF_LUT_VAL);
    assign hit_stat = (adr_w == pcbg_pkg::OFF_STATUS);

    assign gamma_on = (gamma_reg != pcbg_pkg::UNITY);
    assign lut_use = gamma_on | lut_en_reg;
    assign clip_idx = CW'(clip_sel_reg - 4'h1);
    assign clip_rd = (clip_sel_reg == pcbg_pkg::CLIP_SEL_ALL) ? clip_reg[0] : clip_reg[clip_idx];

    assign rdata =
        hit_ctrl ? 32'({lut_en_reg, mode_reg}) :
        hit_csel ? 32'(clip_sel_reg) :
        (hit_cint | hit_cphys) ? 32'(clip_rd) :
        hit_bsel ? 32'(bal_sel_reg) :
        (hit_bm | hit_bl) ? 32'(ratio_reg[bal_sel_reg]) :
        hit_gam ? 32'(gamma_reg) :
        hit_lidx ? 32'(lut_idx_reg) :
        hit_lval ? 32'(lut_sw_data) :
        hit_stat ? 32'({~gamma_on & lut_en_reg, gamma_on, st_reg != pcbg_pkg::AWB_IDLE}) :
        32'h00000000;

    assign wdat = pcbg_pkg::merge32(rdata, wb_dat_w, wb_sel);
    assign wdat_pix = wdat[PW-1:0];
    assign wdat_ratio = wdat[RW-1:0];
    assign ctrl_wr = wr & hit_ctrl;
    assign clip_wr = wr & (hit_cint | hit_cphys);
    assign ratio_wr = wr & (hit_bm | hit_bl) & (wdat_ratio != '0);

    assign wb_ack = ack_reg;
    assign wb_dat_r = dat_reg;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ack_reg <= 1'b0;
            dat_reg <= 32'h00000000;
        end else begin
            ack_reg <= req;
            dat_reg <= req ? rdata : 32'h00000000;
        end
    end

    // ==========================================
    // Configuration registers
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            clip_sel_reg <= pcbg_pkg::CLIP_SEL_ALL;
            bal_sel_reg <= pcbg_pkg::CH_RED;
            gamma_reg <= pcbg_pkg::UNITY;
            lut_idx_reg <= '0;
            lut_en_reg <= 1'b0;
        end else begin
            if (wr && hit_csel && wdat[3:0] <= 4'(NC)) begin
                clip_sel_reg <= wdat[3:0];
            end
            if (wr && hit_bsel) begin
                bal_sel_reg <= wdat[CW-1:0];
            end
            if (wr && hit_gam && wdat_ratio != '0) begin
                gamma_reg <= wdat_ratio;
            end
            if (wr && hit_lidx) begin
                lut_idx_reg <= wdat[pcbg_pkg::LUT_AW-1:0];
            end
            if (ctrl_wr) begin
                lut_en_reg <= wdat[pcbg_pkg::CTRL_LUT_EN];
            end
        end
    end

    always_ff @(posedge clk) begin
        for (int i = 0; i < NC; i++) begin
            if (!rst_n) begin
                clip_reg[i] <= pcbg_pkg::CLIP_RST;
            end else if (clip_wr && (clip_sel_reg == pcbg_pkg::CLIP_SEL_ALL ||
                                     clip_idx == CW'(i))) begin
                clip_reg[i] <= wdat_pix;
            end
        end
    end

    // ==========================================
    // Automatic white balance
    logic in_take;
    logic [PW-1:0] bal_val;
    logic [AWL-1:0] sum_r_reg, sum_g_reg, sum_b_reg;
    logic [pcbg_pkg::AWB_WIN_LOG:0] cnt_reg;
    logic [RND_W-1:0] rnd_reg;
    logic auto_on;
    logic awb_adj;
    logic [RW-1:0] r_next, b_next;
    logic converged;
    logic once_done;

    function automatic logic [RW-1:0] step_ratio(input logic [RW-1:0] r,
                                                input logic [AWL-1:0] s,
                                                input logic [AWL-1:0] g);
        if ({1'b0, s} + {1'b0, pcbg_pkg::AWB_TOL} < {1'b0, g} && r <= ~pcbg_pkg::AWB_STEP) begin
            step_ratio = r + pcbg_pkg::AWB_STEP;
        end else if ({1'b0, s} > {1'b0, g} + {1'b0, pcbg_pkg::AWB_TOL} &&
                     r > pcbg_pkg::AWB_STEP) begin
            step_ratio = r - pcbg_pkg::AWB_STEP;
        end else begin
            step_ratio = r;
        end
    endfunction

    // Vendor hold mode keeps the ratios frozen like off
    assign auto_on = (mode_reg == pcbg_pkg::AWB_ONCE) | (mode_reg == pcbg_pkg::AWB_CONT);
    assign awb_adj = (st_reg == pcbg_pkg::AWB_ADJ) & auto_on;
    assign r_next = step_ratio(ratio_reg[pcbg_pkg::CH_RED], sum_r_reg, sum_g_reg);
    assign b_next = step_ratio(ratio_reg[pcbg_pkg::CH_BLUE], sum_b_reg, sum_g_reg);
    assign converged = (r_next == ratio_reg[pcbg_pkg::CH_RED]) &
                       (b_next == ratio_reg[pcbg_pkg::CH_BLUE]);
    assign once_done = awb_adj & (mode_reg == pcbg_pkg::AWB_ONCE) &
                       (converged | rnd_reg == RND_LAST);

    always_comb begin
        case (st_reg)
            pcbg_pkg::AWB_IDLE: st_next = auto_on ? pcbg_pkg::AWB_ACC : pcbg_pkg::AWB_IDLE;
            pcbg_pkg::AWB_ACC: st_next = !auto_on ? pcbg_pkg::AWB_IDLE :
                cnt_reg[pcbg_pkg::AWB_WIN_LOG] ? pcbg_pkg::AWB_ADJ : pcbg_pkg::AWB_ACC;
            pcbg_pkg::AWB_ADJ: st_next = (auto_on && !once_done) ? pcbg_pkg::AWB_ACC :
                pcbg_pkg::AWB_IDLE;
            default: st_next = pcbg_pkg::AWB_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st_reg <= pcbg_pkg::AWB_IDLE;
            mode_reg <= pcbg_pkg::AWB_OFF;
            rnd_reg <= '0;
        end else begin
            st_reg <= st_next;
            if (ctrl_wr) begin
                mode_reg <= wdat[1:0];
            end else if (once_done) begin
                mode_reg <= pcbg_pkg::AWB_OFF;
            end
            rnd_reg <= (st_reg == pcbg_pkg::AWB_IDLE) ? '0 : rnd_reg + RND_W'(awb_adj);
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n || st_reg != pcbg_pkg::AWB_ACC) begin
            sum_r_reg <= '0;
            sum_g_reg <= '0;
            sum_b_reg <= '0;
            cnt_reg <= '0;
        end else if (in_take && !cnt_reg[pcbg_pkg::AWB_WIN_LOG]) begin
            cnt_reg <= cnt_reg + 1'b1;
            sum_r_reg <= sum_r_reg + AWL'(pix_in_chan == pcbg_pkg::CH_RED ? bal_val : '0);
            sum_g_reg <= sum_g_reg + AWL'(pix_in_chan == pcbg_pkg::CH_GREEN ? bal_val : '0);
            sum_b_reg <= sum_b_reg + AWL'(pix_in_chan == pcbg_pkg::CH_BLUE ? bal_val : '0);
        end
    end

    always_ff @(posedge clk) begin
        for (int i = 0; i < NC; i++) begin
            if (!rst_n) begin
                ratio_reg[i] <= pcbg_pkg::UNITY;
            end else if (ratio_wr && bal_sel_reg == CW'(i)) begin
                ratio_reg[i] <= wdat_ratio;
            end else if (awb_adj && CW'(i) == pcbg_pkg::CH_RED) begin
                ratio_reg[i] <= r_next;
            end else if (awb_adj && CW'(i) == pcbg_pkg::CH_BLUE) begin
                ratio_reg[i] <= b_next;
            end
        end
    end

    // ==========================================
    // Pixel path
    pcbg_stream_if #(.DW(CW + PW)) bi();
    pcbg_stream_if #(.DW(CW + PW)) bo();

    logic s1_valid_reg;
    logic [PW-1:0] s1_data_reg;
    logic [CW-1:0] s1_chan_reg;
    logic [PW-1:0] lk_data;
    logic [PW-1:0] g_val;
    logic [PW-1:0] clipped;

    assign pix_in_ready = ~s1_valid_reg | bi.ready;
    assign in_take = pix_in_valid & pix_in_ready;
    assign bal_val = pcbg_pkg::scale_sat(pix_in_data, ratio_reg[pix_in_chan]);
    assign g_val = lut_use ? lk_data : s1_data_reg;
    assign clipped = pcbg_pkg::clip_min(g_val, clip_reg[s1_chan_reg]);
    assign bi.valid = s1_valid_reg;
    assign bi.data = {s1_chan_reg, clipped};

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s1_valid_reg <= 1'b0;
            s1_data_reg <= '0;
            s1_chan_reg <= '0;
        end else if (pix_in_ready) begin
            s1_valid_reg <= pix_in_valid;
            s1_data_reg <= bal_val;
            s1_chan_reg <= pix_in_chan;
        end
    end

    pcbg_lut #(.AW(pcbg_pkg::LUT_AW), .DW(PW)) u_lut (
        .clk(clk),
        .rst_n(rst_n),
        .wr_en(wr & hit_lval),
        .wr_addr(lut_idx_reg),
        .wr_data(wdat_pix),
        .sw_addr(lut_idx_reg),
        .sw_data(lut_sw_data),
        .lk_addr(s1_data_reg[PW-1 -: pcbg_pkg::LUT_AW]),
        .lk_data(lk_data)
    );

    pcbg_fifo #(.DW(CW + PW), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk(clk),
        .rst_n(rst_n),
        .up(bi),
        .dn(bo)
    );

    assign pix_out_valid = bo.valid;
    assign bo.ready = pix_out_ready;
    assign pix_out_data = bo.data[PW-1:0];
    assign pix_out_chan = bo.data[CW+PW-1:PW];

    // ==========================================
    // Checks
    a_clip_all_write: assert property (
        (clip_wr && clip_sel_reg == pcbg_pkg::CLIP_SEL_ALL) |=>
        (clip_reg[0] == $past(wdat_pix) && clip_reg[NC-1] == $past(wdat_pix)))
        else $error("clip write to all channels missed");
    a_clip_ceiling: assert property (
        bi.valid |-> bi.data[PW-1:0] <= clip_reg[s1_chan_reg] &&
        (bi.data[PW-1:0] == g_val || bi.data[PW-1:0] == clip_reg[s1_chan_reg]))
        else $error("pixel above clip level");
    a_clip_one_chan: assert property (
        (clip_wr && clip_sel_reg != pcbg_pkg::CLIP_SEL_ALL) |=>
        clip_reg[$past(clip_idx)] == $past(wdat_pix))
        else $error("selected clip level not written");
    a_clip_alias: assert property (
        (wr && hit_cphys) |=> clip_rd == $past(wdat_pix))
        else $error("raw clip form not reflecting physical write");
    a_bal_product: assert property (
        in_take |=> (s1_data_reg == '1 || s1_data_reg ==
        $past(PW'(({16'h0000, pix_in_data} * ratio_reg[pix_in_chan]) >> 8))) &&
        $past(ratio_reg[pix_in_chan]) != '0)
        else $error("balance product wrong");
    a_awb_off_hold: assert property (
        (mode_reg == pcbg_pkg::AWB_OFF && !ratio_wr) |=>
        ratio_reg[pcbg_pkg::CH_RED] == $past(ratio_reg[pcbg_pkg::CH_RED]))
        else $error("ratio moved with auto balance off");
    a_once_to_off: assert property (
        (once_done && !ctrl_wr) |=> mode_reg == pcbg_pkg::AWB_OFF ##1 st_reg == pcbg_pkg::AWB_IDLE)
        else $error("single-shot did not return to off");
    a_cont_stays: assert property (
        (mode_reg == pcbg_pkg::AWB_CONT && st_reg == pcbg_pkg::AWB_ADJ && !ctrl_wr) |=>
        mode_reg == pcbg_pkg::AWB_CONT && st_reg == pcbg_pkg::AWB_ACC)
        else $error("continuous balance stopped");
    a_gamma_unity: assert property (
        (bi.valid && !lut_use) |-> bi.data[PW-1:0] == pcbg_pkg::clip_min(s1_data_reg,
                                                                          clip_reg[s1_chan_reg]))
        else $error("unity gamma altered pixel");
    a_gamma_pos: assert property (
        gamma_reg != '0)
        else $error("gamma factor zero");
endmodule

//--- dv/pcbg_pix_sink.sv
`timescale 1ns/1ps
module pcbg_pix_sink (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic stall_en,
    output logic ready
);
    // ==========================================
    // Downstream sink, random back-pressure while stalling
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ready <= 1'b0;
        end else begin
            ready <= stall_en ? 1'($urandom_range(1)) : 1'b1;
        end
    end
endmodule

//--- dv/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic wb_cyc = 1'b0;
    logic wb_stb = 1'b0;
    logic wb_we = 1'b0;
    logic [7:0] wb_adr = 8'h00;
    logic [3:0] wb_sel = 4'hf;
    logic [31:0] wb_dat_w = 32'h0;
    logic [31:0] wb_dat_r;
    logic [31:0] rd;
    logic wb_ack;
    logic pix_in_valid = 1'b0;
    logic pix_in_ready;
    logic [11:0] pix_in_data = 12'h000;
    logic [2:0] pix_in_chan = 3'h0;
    logic pix_out_valid;
    logic pix_out_ready;
    logic [11:0] pix_out_data;
    logic [2:0] pix_out_chan;
    logic stall_en = 1'b0;
    logic chk_en = 1'b1;
    logic lut_on = 1'b0;
    logic [15:0] ratio [8];
    logic [11:0] clip [8];
    logic [14:0] exp_q [$];
    int err_total = 0;
    int num_checks = 0;
    int cycles = 0;

    always #12.5 clk = ~clk;

    pcbg_top #(.FIFO_DEPTH(2)) u_pcbg_top (
        .clk(clk), .rst_n(rst_n), .wb_cyc(wb_cyc), .wb_stb(wb_stb), .wb_we(wb_we),
        .wb_adr(wb_adr), .wb_sel(wb_sel), .wb_dat_w(wb_dat_w), .wb_dat_r(wb_dat_r),
        .wb_ack(wb_ack), .pix_in_valid(pix_in_valid), .pix_in_ready(pix_in_ready),
        .pix_in_data(pix_in_data), .pix_in_chan(pix_in_chan), .pix_out_valid(pix_out_valid),
        .pix_out_ready(pix_out_ready), .pix_out_data(pix_out_data), .pix_out_chan(pix_out_chan)
    );

    pcbg_pix_sink u_pcbg_pix_sink (
        .clk(clk), .rst_n(rst_n), .stall_en(stall_en), .ready(pix_out_ready)
    );

    // ==========================================
    // Checking and closing
    task automatic finish_test();
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    function automatic logic [11:0] exp_pix(input logic [11:0] p, input logic [2:0] c);
        logic [27:0] prod;
        logic [11:0] s;
        prod = p * ratio[c];
        s = (|prod[27:20]) ? 12'hfff : prod[19:8];
        s = lut_on ? {s[11:6], 6'h00} : s;
        return (s > clip[c]) ? clip[c] : s;
    endfunction

    // ==========================================
    // Bus and stream drivers
    task automatic wb_xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                           input logic [3:0] s = 4'hf);
        @(posedge clk);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= w;
        wb_adr <= a;
        wb_dat_w <= d;
        wb_sel <= s;
        @(posedge clk);
        while (wb_ack !== 1'b1) @(posedge clk);
        rd = wb_dat_r;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        wb_we <= 1'b0;
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        wb_xfer(1'b0, a, 32'h0);
        check(rd, exp, "register read");
    endtask

    task automatic burst(input int n, input int mode);
        logic [2:0] c;
        logic [11:0] p;
        @(posedge clk);
        for (int i = 0; i < n; i++) begin
            c = (mode == 0) ? 3'($urandom_range(7)) : 3'(i % 3);
            p = (mode == 0) ? ((i % 8 == 0) ? 12'hfff : 12'($urandom)) : 12'h400;
            p = (mode == 2 && c == pcbg_pkg::CH_RED) ? 12'h200 : p;
            pix_in_valid <= 1'b1;
            pix_in_chan <= c;
            pix_in_data <= p;
            @(posedge clk);
            while (pix_in_ready !== 1'b1) @(posedge clk);
            if (chk_en) exp_q.push_back({c, exp_pix(p, c)});
        end
        pix_in_valid <= 1'b0;
        for (int i = 0; i < 300 && exp_q.size() != 0; i++) @(posedge clk);
        check(exp_q.size(), 0, "pixels lost");
    endtask

    always @(negedge clk) begin
        if (rst_n && pix_out_valid && pix_out_ready && chk_en) begin
            if (exp_q.size() == 0) check(1, 0, "extra pixel");
            else check({pix_out_chan, pix_out_data}, exp_q.pop_front(), "pixel");
        end
    end

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            err_total++;
            finish_test();
        end
    end

    // ==========================================
    // Test sequence
    initial begin
        void'($urandom(43));
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        rdchk(pcbg_pkg::OFF_CLIP_INT, 32'h0fff);
        rdchk(pcbg_pkg::OFF_BAL_MULT, 32'h0100);
        rdchk(8'h3c, 32'h0);
        wb_xfer(1'b1, pcbg_pkg::OFF_CLIP_SEL, 32'h0);
        wb_xfer(1'b1, pcbg_pkg::OFF_CLIP_INT, 32'h0900);
        wb_xfer(1'b1, pcbg_pkg::OFF_CLIP_SEL, 32'h6);
        rdchk(pcbg_pkg::OFF_CLIP_PHYS, 32'h0900);
        for (int c = 0; c < 8; c++) begin
            clip[c] = 12'h600 + 12'($urandom_range(2559));
            ratio[c] = 16'h0080 + 16'($urandom_range(384));
            wb_xfer(1'b1, pcbg_pkg::OFF_CLIP_SEL, 32'(c + 1));
            wb_xfer(1'b1, c[0] ? pcbg_pkg::OFF_CLIP_PHYS : pcbg_pkg::OFF_CLIP_INT, 32'(clip[c]));
            wb_xfer(1'b1, pcbg_pkg::OFF_BAL_SEL, 32'(c));
            wb_xfer(1'b1, c[0] ? pcbg_pkg::OFF_BAL_LEGACY : pcbg_pkg::OFF_BAL_MULT, 32'(ratio[c]));
        end
        wb_xfer(1'b1, pcbg_pkg::OFF_CLIP_SEL, 32'h9);
        rdchk(pcbg_pkg::OFF_CLIP_SEL, 32'h8);
        wb_xfer(1'b1, pcbg_pkg::OFF_CLIP_INT, 32'h0eab, 4'h1);
        clip[7] = {clip[7][11:8], 8'hab};
        wb_xfer(1'b1, pcbg_pkg::OFF_BAL_MULT, 32'h0);
        for (int c = 0; c < 8; c++) begin
            wb_xfer(1'b1, pcbg_pkg::OFF_CLIP_SEL, 32'(c + 1));
            rdchk(c[0] ? pcbg_pkg::OFF_CLIP_INT : pcbg_pkg::OFF_CLIP_PHYS, 32'(clip[c]));
            wb_xfer(1'b1, pcbg_pkg::OFF_BAL_SEL, 32'(c));
            rdchk(c[0] ? pcbg_pkg::OFF_BAL_MULT : pcbg_pkg::OFF_BAL_LEGACY, 32'(ratio[c]));
        end
        $display("test registers done");
        stall_en <= 1'b1;
        burst(400, 0);
        stall_en <= 1'b0;
        burst(40, 0);
        $display("test stream done");
        wb_xfer(1'b1, pcbg_pkg::OFF_GAMMA, 32'h0);
        rdchk(pcbg_pkg::OFF_GAMMA, 32'h0100);
        wb_xfer(1'b1, pcbg_pkg::OFF_GAMMA, 32'h0200);
        rdchk(pcbg_pkg::OFF_STATUS, 32'h2);
        wb_xfer(1'b1, pcbg_pkg::OFF_LUT_IDX, 32'h5);
        wb_xfer(1'b1, pcbg_pkg::OFF_LUT_VAL, 32'h017f);
        rdchk(pcbg_pkg::OFF_LUT_VAL, 32'h017f);
        wb_xfer(1'b1, pcbg_pkg::OFF_LUT_VAL, 32'h0140);
        lut_on = 1'b1;
        burst(60, 0);
        lut_on = 1'b0;
        wb_xfer(1'b1, pcbg_pkg::OFF_GAMMA, 32'h0100);
        wb_xfer(1'b1, pcbg_pkg::OFF_CTRL, 32'h3);
        rdchk(pcbg_pkg::OFF_CTRL, 32'h3);
        $display("test gamma and modes done");
        chk_en <= 1'b0;
        for (int c = 0; c < 3; c++) begin
            wb_xfer(1'b1, pcbg_pkg::OFF_BAL_SEL, 32'(c));
            wb_xfer(1'b1, pcbg_pkg::OFF_BAL_MULT, 32'h0100);
        end
        wb_xfer(1'b1, pcbg_pkg::OFF_CTRL, 32'h1);
        burst(900, 1);
        rdchk(pcbg_pkg::OFF_CTRL, 32'h0);
        wb_xfer(1'b1, pcbg_pkg::OFF_CTRL, 32'h2);
        burst(1500, 2);
        rdchk(pcbg_pkg::OFF_CTRL, 32'h2);
        wb_xfer(1'b1, pcbg_pkg::OFF_BAL_SEL, 32'h0);
        wb_xfer(1'b1, pcbg_pkg::OFF_CTRL, 32'h0);
        wb_xfer(1'b0, pcbg_pkg::OFF_BAL_MULT, 32'h0);
        check(32'(rd[15:0] != 16'h0100), 32'h1, "auto step");
        burst(300, 2);
        rdchk(pcbg_pkg::OFF_BAL_MULT, rd);
        $display("test auto balance done");
        finish_test();
    end
endmodule
